// ==== hdl/dlci_pkg.sv ====
// constants and carrier types for the drive link command interpreter
// Notes on behaviour
// (R1) forward request high runs forward; low means stop.
// (R2) reverse request high runs reverse; low means stop.
// (R3) both direction requests high together give a stop.
// (R4) by default the three speed select bits pick a preset speed.
// (R5) output halt request high stops the power output.
// (R6) configuration reassigns command bits among speed selects and halt.
// (R7) monitor request rise loads the result word, then raises monitor ack.
// (R8) while monitor request stays high the result word keeps refreshing.
// (R9) volatile write rise copies set frequency, then raises its ack.
// (R10) non-volatile write rise stores set frequency, then raises its ack.
// (R11) while volatile request stays high the set frequency keeps being taken.
// (R12) execute request rise runs the coded operation, then raises done.
// (R13) failed instruction gives a nonzero reply code; success gives zero.
// (R14) simultaneous write/write/execute requests: only one is carried out.
// (R15) fault clear request rise with a fault present clears fault status.
// (R16) master keeps every reserved command bit at zero.
// (R17) monitor ack drops when the monitor request drops.
// (R18) volatile write ack drops when the volatile request drops.
// (R19) fault status rises whenever a protective trip reports a drive error.
// (R20) after reset all acks, done and reply code stay zero.
package dlci_pkg;
    localparam int CMD_W = 32;
    // command word bit positions
    localparam int BIT_FWD = 0;
    localparam int BIT_REV = 1;
    localparam int BIT_SPD_HIGH = 2;
    localparam int BIT_SPD_MID = 3;
    localparam int BIT_SPD_LOW = 4;
    localparam int BIT_HALT = 9;
    localparam int BIT_MON = 12;
    localparam int BIT_FWR_VOL = 13;
    localparam int BIT_FWR_NV = 14;
    localparam int BIT_EXEC = 15;
    localparam int BIT_FCLR = 26;
    localparam logic [31:0] RESERVED_MASK = 32'hFBFF_0DE0;
    // status word bit positions
    localparam int SBIT_FWD = 0;
    localparam int SBIT_REV = 1;
    localparam int SBIT_RUN = 2;
    localparam int SBIT_MON = 12;
    localparam int SBIT_FWR_VOL = 13;
    localparam int SBIT_FWR_NV = 14;
    localparam int SBIT_DONE = 15;
    localparam int SBIT_FAULT = 26;
    localparam int SBIT_RSVD_ERR = 27;
    // register byte addresses
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_SETFREQ = 8'h04;
    localparam logic [7:0] ADDR_INSTR = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MONRES = 8'h10;
    localparam logic [7:0] ADDR_REPLY = 8'h14;
    localparam logic [7:0] ADDR_VOLFREQ = 8'h18;
    localparam logic [7:0] ADDR_NVFREQ = 8'h1C;
    localparam logic [7:0] ADDR_FUNCSEL = 8'h20;
    localparam logic [7:0] ADDR_SPEED = 8'h24;
    // function codes for the reassignable bit positions
    localparam logic [1:0] FN_HIGH = 2'h0;
    localparam logic [1:0] FN_MID = 2'h1;
    localparam logic [1:0] FN_LOW = 2'h2;
    localparam logic [1:0] FN_HALT = 2'h3;
    // funcsel reset: slot0=high, slot1=mid, slot2=low, slot3=halt
    localparam logic [7:0] FUNCSEL_RST = 8'hE4;
    // instruction codes understood here; others fail
    localparam logic [15:0] IC_NOP = 16'h0000;
    localparam logic [15:0] IC_MON_SEL = 16'h00F3;
    localparam logic [15:0] REPLY_OK = 16'h0000;
    localparam logic [15:0] REPLY_BAD_CODE = 16'h0001;
    localparam int NV_WRITE_CYCLES = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DLCI_DIR_STOP,
        DLCI_DIR_FWD,
        DLCI_DIR_REV
    } dlci_dir_type;

    typedef struct packed {
        dlci_dir_type dir;
        logic [2:0] speed_sel;
        logic halt;
    } dlci_drive_type;

    typedef struct packed {
        logic [15:0] output_freq;
        logic [15:0] output_current;
        logic [15:0] output_voltage;
        logic [15:0] special;
    } dlci_monitor_type;
endpackage

// ==== hdl/dlci_top.sv ====
// drive link command interpreter with an axi4-lite register slave
`timescale 1ns/1ps
module dlci_top #(
    parameter int NV_CYCLES = dlci_pkg::NV_WRITE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dlci_pkg::dlci_monitor_type monitor_in,
    input wire logic nv_write_done,
    input wire logic drive_trip,
    output dlci_pkg::dlci_drive_type drive_cmd,
    output logic nv_write_start,
    output logic [15:0] nv_write_data,
    output logic drive_reset
);
    import dlci_pkg::*;

    if (NV_CYCLES < 1 || NV_CYCLES > 65535) begin : g_nv_range
        $error("NV_CYCLES out of range");
    end

    logic [31:0] cmd_q;
    logic [15:0] set_freq_q;
    logic [15:0] instr_q;
    logic [7:0] funcsel_q;
    logic [1:0] mon_sel_q;
    logic [15:0] mon_result_q;
    logic [15:0] reply_q;
    logic [15:0] vol_freq_q;
    logic [15:0] nv_freq_q;
    logic mon_ack_q, vol_ack_q, nv_ack_q, done_q, fault_q, rsvd_err_q;
    logic [31:0] cmd_prev_q;
    logic nv_busy_q;
    logic [15:0] nv_cnt_q;
    dlci_drive_type drive_q;
    logic drive_reset_q;

    // axi write and read channel state
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    logic wr_fire;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_q <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic wr_known;
    assign wr_known = aw_addr_q <= ADDR_SPEED && aw_addr_q[1:0] == 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // writable registers; read-only addresses accept and ignore writes, except that a status write clears the reserved-bit flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_q <= 32'h0000_0000;
            set_freq_q <= 16'h0000;
            instr_q <= 16'h0000;
            funcsel_q <= FUNCSEL_RST;
        end else if (wr_fire) begin
            unique case (aw_addr_q)
                ADDR_CMD: cmd_q <= merge(cmd_q, w_data_q, w_strb_q);
                ADDR_SETFREQ: set_freq_q <= 16'(merge({16'h0000, set_freq_q}, w_data_q, w_strb_q));
                ADDR_INSTR: instr_q <= 16'(merge({16'h0000, instr_q}, w_data_q, w_strb_q));
                ADDR_FUNCSEL: funcsel_q <= 8'(merge({24'h000000, funcsel_q}, w_data_q, w_strb_q));
                default: ;
            endcase
        end
    end

    // request edges
    logic mon_req, vol_req, nv_req, exec_req, fclr_req;
    assign mon_req = cmd_q[BIT_MON];
    assign vol_req = cmd_q[BIT_FWR_VOL];
    assign nv_req = cmd_q[BIT_FWR_NV];
    assign exec_req = cmd_q[BIT_EXEC];
    assign fclr_req = cmd_q[BIT_FCLR];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_prev_q <= 32'h0000_0000;
        end else begin
            cmd_prev_q <= cmd_q;
        end
    end

    logic vol_rise, nv_rise, exec_rise;
    assign vol_rise = vol_req && !cmd_prev_q[BIT_FWR_VOL];
    assign nv_rise = nv_req && !cmd_prev_q[BIT_FWR_NV];
    assign exec_rise = exec_req && !cmd_prev_q[BIT_EXEC];

    // one winner per cycle: volatile, then non-volatile, then execute [R14]
    logic do_vol, do_nv, do_exec;
    assign do_vol = vol_rise;
    assign do_nv = nv_rise && !vol_rise && !nv_busy_q;
    assign do_exec = exec_rise && !vol_rise && !nv_rise;

    // drive outputs
    logic [3:0] slot_bits;
    assign slot_bits = {cmd_q[BIT_HALT], cmd_q[BIT_SPD_LOW], cmd_q[BIT_SPD_MID], cmd_q[BIT_SPD_HIGH]};
    dlci_drive_type drive_d;
    always_comb begin
        drive_d.speed_sel = 3'h0;
        drive_d.halt = 1'b0;
        // each slot maps to a function, so the halt may sit on any of the four [R6]
        for (int i = 0; i < 4; i++) begin
            unique case (funcsel_q[i*2 +: 2])
                FN_HIGH: drive_d.speed_sel[2] = drive_d.speed_sel[2] | slot_bits[i]; // [R4]
                FN_MID: drive_d.speed_sel[1] = drive_d.speed_sel[1] | slot_bits[i]; // [R4]
                FN_LOW: drive_d.speed_sel[0] = drive_d.speed_sel[0] | slot_bits[i]; // [R4]
                FN_HALT: drive_d.halt = drive_d.halt | slot_bits[i]; // [R5]
            endcase
        end
        if (cmd_q[BIT_FWD] && cmd_q[BIT_REV]) begin
            drive_d.dir = DLCI_DIR_STOP; // [R3]
        end else if (cmd_q[BIT_FWD]) begin
            drive_d.dir = DLCI_DIR_FWD; // [R1]
        end else if (cmd_q[BIT_REV]) begin
            drive_d.dir = DLCI_DIR_REV; // [R2]
        end else begin
            drive_d.dir = DLCI_DIR_STOP; // [R1] [R2]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_q <= '{dir: DLCI_DIR_STOP, speed_sel: 3'h0, halt: 1'b0};
        end else begin
            drive_q <= drive_d;
        end
    end
    assign drive_cmd = drive_q;

    // monitor handshake: result loaded first, ack one cycle later
    logic [15:0] mon_value;
    // selector 0 is the top field of the struct
    assign mon_value = monitor_in[{~mon_sel_q, 4'h0} +: 16];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_result_q <= 16'h0000;
            mon_ack_q <= 1'b0;
        end else if (mon_req) begin
            mon_result_q <= mon_value; // [R7] [R8]
            mon_ack_q <= cmd_prev_q[BIT_MON]; // [R7]
        end else begin
            mon_ack_q <= 1'b0; // [R17]
        end
    end

    // volatile frequency write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vol_freq_q <= 16'h0000;
            vol_ack_q <= 1'b0;
        end else if (!vol_req) begin
            vol_ack_q <= 1'b0; // [R18]
        end else if (do_vol) begin
            vol_freq_q <= set_freq_q; // [R9]
        end else if (vol_ack_q || cmd_prev_q[BIT_FWR_VOL]) begin
            vol_freq_q <= set_freq_q; // [R11]
            vol_ack_q <= 1'b1; // [R9]
        end
    end

    // non-volatile write: one store cycle then wait for the storage to finish
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_busy_q <= 1'b0;
            nv_cnt_q <= 16'h0000;
            nv_freq_q <= 16'h0000;
            nv_ack_q <= 1'b0;
        end else begin
            if (do_nv) begin
                nv_busy_q <= 1'b1; // [R10]
                nv_cnt_q <= 16'(NV_CYCLES);
                nv_freq_q <= set_freq_q;
            end else if (nv_busy_q) begin
                if (nv_cnt_q != 16'h0000) begin
                    nv_cnt_q <= nv_cnt_q - 16'h0001;
                end
                // the store stays busy until both the minimum time and storage agree
                if (nv_cnt_q <= 16'h0001 && nv_write_done) begin
                    nv_busy_q <= 1'b0;
                    nv_ack_q <= nv_req; // [R10]
                end
            end
            if (!nv_req) begin
                nv_ack_q <= 1'b0;
            end
        end
    end
    assign nv_write_start = do_nv;
    assign nv_write_data = nv_freq_q;

    // instruction execution: done one cycle after the request edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0; // [R20]
            reply_q <= REPLY_OK; // [R20]
            mon_sel_q <= 2'h0;
        end else if (do_exec) begin
            done_q <= 1'b1; // [R12]
            unique case (instr_q)
                IC_NOP: reply_q <= REPLY_OK; // [R13]
                IC_MON_SEL: reply_q <= REPLY_OK; // [R13]
                default: reply_q <= REPLY_BAD_CODE; // [R13]
            endcase
            if (instr_q == IC_MON_SEL) begin
                mon_sel_q <= 2'h3;
            end
        end else if (!exec_req) begin
            done_q <= 1'b0;
        end
    end

    // fault status: a trip in the clear cycle wins over the clear
    logic fclr_rise;
    assign fclr_rise = fclr_req && !cmd_prev_q[BIT_FCLR];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_q <= 1'b0;
            drive_reset_q <= 1'b0;
        end else begin
            drive_reset_q <= fclr_rise && fault_q && !drive_trip; // [R15]
            if (drive_trip) begin
                fault_q <= 1'b1; // [R19]
            end else if (fclr_rise && fault_q) begin
                fault_q <= 1'b0; // [R15]
            end
        end
    end
    assign drive_reset = drive_reset_q;

    // reserved command bits are the master's to keep low; flag any seen high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsvd_err_q <= 1'b0;
        end else if ((cmd_q & RESERVED_MASK) != 32'h0000_0000) begin
            rsvd_err_q <= 1'b1; // [R16]
        end else if (wr_fire && aw_addr_q == ADDR_STATUS) begin
            rsvd_err_q <= 1'b0;
        end
    end

    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[SBIT_FWD] = drive_q.dir == DLCI_DIR_FWD;
        status_word[SBIT_REV] = drive_q.dir == DLCI_DIR_REV;
        status_word[SBIT_RUN] = drive_q.dir != DLCI_DIR_STOP && !drive_q.halt;
        status_word[SBIT_MON] = mon_ack_q;
        status_word[SBIT_FWR_VOL] = vol_ack_q;
        status_word[SBIT_FWR_NV] = nv_ack_q;
        status_word[SBIT_DONE] = done_q;
        status_word[SBIT_FAULT] = fault_q;
        status_word[SBIT_RSVD_ERR] = rsvd_err_q;
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CMD: rdata_q <= cmd_q;
                ADDR_SETFREQ: rdata_q <= {16'h0000, set_freq_q};
                ADDR_INSTR: rdata_q <= {16'h0000, instr_q};
                ADDR_STATUS: rdata_q <= status_word;
                ADDR_MONRES: rdata_q <= {16'h0000, mon_result_q};
                ADDR_REPLY: rdata_q <= {16'h0000, reply_q};
                ADDR_VOLFREQ: rdata_q <= {16'h0000, vol_freq_q};
                ADDR_NVFREQ: rdata_q <= {16'h0000, nv_freq_q};
                ADDR_FUNCSEL: rdata_q <= {24'h000000, funcsel_q};
                ADDR_SPEED: rdata_q <= {29'h0, drive_q.speed_sel};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule // dlci_top

// ==== sim/dlci_drive_model.sv ====
// drive side model: monitor source, storage busy handshake and trip source
`timescale 1ns/1ps
module dlci_drive_model #(
    parameter int BUSY = 5
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic nv_write_start,
    input wire logic [15:0] mon_val,
    input wire logic trip_req,
    output dlci_pkg::dlci_monitor_type monitor_in,
    output logic nv_write_done,
    output logic drive_trip
);
    import dlci_pkg::*;
    int busy_q;
    // storage is slow on purpose so the interpreter must wait for it
    always_ff @(posedge aclk) begin
        if (!aresetn) busy_q <= 0;
        else if (nv_write_start) busy_q <= BUSY;
        else if (busy_q != 0) busy_q <= busy_q - 1;
    end
    assign nv_write_done = (busy_q == 0);
    assign drive_trip = trip_req;
    assign monitor_in = '{output_freq: mon_val, output_current: ~mon_val,
        output_voltage: {mon_val[7:0], mon_val[15:8]}, special: mon_val ^ 16'h5A5A};
endmodule // dlci_drive_model

// ==== sim/dlci_top_asserts.sv ====
// concurrent checks on the ports of the command interpreter top
`timescale 1ns/1ps
module dlci_top_asserts #(
    parameter int NV_CYCLES = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dlci_pkg::dlci_drive_type drive_cmd,
    input wire logic nv_write_start,
    input wire logic drive_reset
);
    import dlci_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] wa_q;
    logic [31:0] wd_q;
    logic [31:0] sh_q;
    // last accepted write; the command shadow lags so rising bits can be seen
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) sh_q <= 32'h0;
        else if (s_axi_bvalid && s_axi_bready && wa_q == ADDR_CMD) sh_q <= wd_q;
    end
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while read pending");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    nv_pulse_a: assert property (nv_write_start |=> !nv_write_start)
        else $error("storage start longer than one cycle");
    reset_pulse_a: assert property (drive_reset |=> !drive_reset)
        else $error("drive reset longer than one cycle");
    dir_follow_a: assert property ($rose(s_axi_bvalid) && wa_q == ADDR_CMD |-> ##[1:2]
        drive_cmd.dir == ((wd_q[BIT_FWD] && !wd_q[BIT_REV]) ? DLCI_DIR_FWD
        : (wd_q[BIT_REV] && !wd_q[BIT_FWD]) ? DLCI_DIR_REV : DLCI_DIR_STOP))
        else $error("drive direction does not follow command word");
    nv_start_a: assert property ($rose(s_axi_bvalid) && wa_q == ADDR_CMD
        && wd_q[BIT_FWR_NV] && !sh_q[BIT_FWR_NV] && !(wd_q[BIT_FWR_VOL] && !sh_q[BIT_FWR_VOL])
        |-> ##[0:1] nv_write_start)
        else $error("rising storage request gave no start");
    reset_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
        && !nv_write_start && !drive_reset && s_axi_awready && s_axi_arready)
        else $error("outputs not idle after reset");
endmodule // dlci_top_asserts

bind dlci_top dlci_top_asserts #(.NV_CYCLES(NV_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .drive_cmd(drive_cmd), .nv_write_start(nv_write_start),
    .drive_reset(drive_reset));

// ==== sim/drive_link_command_handshake_test.sv ====
// self-checking bench for the drive link command interpreter
`timescale 1ns/1ps
module drive_link_command_handshake_test;
    import dlci_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, nv_write_done, drive_trip, nv_write_start, drive_reset;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] nv_write_data;
    logic [15:0] mon_val = 16'h0;
    logic trip_req = 1'h0;
    dlci_monitor_type monitor_in;
    dlci_drive_type drive_cmd;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rdat;
    logic [1:0] rrsp;
    logic [15:0] codes [3] = '{IC_NOP, IC_MON_SEL, 16'h0055};

    always #2.5 aclk = ~aclk;

    dlci_top #(.NV_CYCLES(2)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .monitor_in(monitor_in), .nv_write_done(nv_write_done), .drive_trip(drive_trip),
        .drive_cmd(drive_cmd), .nv_write_start(nv_write_start), .nv_write_data(nv_write_data),
        .drive_reset(drive_reset));
    dlci_drive_model #(.BUSY(5)) u_drive (.aclk(aclk), .aresetn(aresetn), .nv_write_start(nv_write_start),
        .mon_val(mon_val), .trip_req(trip_req), .monitor_in(monitor_in), .nv_write_done(nv_write_done),
        .drive_trip(drive_trip));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // bready is raised late so the slave must hold its response
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha = 1'h0;
        logic hw = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            ha = ha || awready;
            hw = hw || wready;
            if (ha) awvalid <= 1'h0;
            if (hw) wvalid <= 1'h0;
        end while (!(ha && hw));
        repeat (2) @(posedge aclk);
        bready <= 1'h1;
        do @(posedge aclk); while (!bvalid);
        rrsp = bresp;
        bready <= 1'h0;
        chk("write response", RESP_OKAY, rrsp);
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        repeat (2) @(posedge aclk);
        rready <= 1'h1;
        do @(posedge aclk); while (!rvalid);
        rdat = rdata;
        rrsp = rresp;
        rready <= 1'h0;
    endtask

    task automatic cmd(input logic [31:0] v);
        wr(ADDR_CMD, v & ~RESERVED_MASK);
    endtask

    task automatic poll(input int b, input logic v, input string n);
        for (int k = 0; k < 40; k++) begin
            rd(ADDR_STATUS);
            if (rdat[b] === v) break;
        end
        chk(n, {31'h0, v}, {31'h0, rdat[b]});
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(ADDR_STATUS);
        chk("status after reset", 32'h0, rdat);
        rd(ADDR_REPLY);
        chk("reply after reset", 32'h0, rdat);
        rd(ADDR_FUNCSEL);
        chk("funcsel reset", {24'h0, FUNCSEL_RST}, rdat);
        for (int i = 0; i < 4; i++) begin
            cmd(i);
            chk("dir", (i == 1) ? DLCI_DIR_FWD : (i == 2) ? DLCI_DIR_REV : DLCI_DIR_STOP, drive_cmd.dir);
        end
        for (int i = 0; i < 8; i++) begin
            cmd((i << 2) | ((i & 1) << 9));
            chk("speed", {i[0], i[1], i[2]}, drive_cmd.speed_sel);
            chk("halt", i & 1, drive_cmd.halt);
        end
        wr(ADDR_FUNCSEL, 32'h27);
        cmd(32'h4);
        chk("moved halt", 32'h1, drive_cmd.halt);
        cmd(32'h200);
        chk("moved high", 32'h4, drive_cmd.speed_sel);
        wr(ADDR_FUNCSEL, {24'h0, FUNCSEL_RST});
        @(posedge aclk);
        mon_val <= 16'h1234;
        cmd(32'h1000);
        poll(SBIT_MON, 1'h1, "monitor ack");
        rd(ADDR_MONRES);
        chk("monitor word", 32'h1234, rdat);
        @(posedge aclk);
        mon_val <= 16'hBEEF;
        rd(ADDR_MONRES);
        chk("monitor refresh", 32'hBEEF, rdat);
        cmd(32'h0);
        poll(SBIT_MON, 1'h0, "monitor ack drop");
        wr(ADDR_SETFREQ, 32'h1388);
        cmd(32'h2000);
        poll(SBIT_FWR_VOL, 1'h1, "volatile ack");
        rd(ADDR_VOLFREQ);
        chk("volatile copy", 32'h1388, rdat);
        wr(ADDR_SETFREQ, 32'h0FA0);
        rd(ADDR_VOLFREQ);
        chk("volatile follow", 32'h0FA0, rdat);
        cmd(32'h0);
        poll(SBIT_FWR_VOL, 1'h0, "volatile ack drop");
        wr(ADDR_SETFREQ, 32'h0ABC);
        cmd(32'h4000);
        poll(SBIT_FWR_NV, 1'h1, "nv ack");
        rd(ADDR_NVFREQ);
        chk("nv stored", 32'h0ABC, rdat);
        chk("nv data", 32'h0ABC, nv_write_data);
        cmd(32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_INSTR, codes[i]);
            cmd(32'h8000);
            poll(SBIT_DONE, 1'h1, "instruction done");
            rd(ADDR_REPLY);
            chk("reply", (i == 2) ? REPLY_BAD_CODE : REPLY_OK, rdat);
            cmd(32'h0);
        end
        cmd(32'h1000);
        poll(SBIT_MON, 1'h1, "special ack");
        rd(ADDR_MONRES);
        chk("special monitor", 32'hE4B5, rdat);
        wr(ADDR_SETFREQ, 32'h0321);
        cmd(32'hE000);
        poll(SBIT_FWR_VOL, 1'h1, "volatile wins");
        rd(ADDR_NVFREQ);
        chk("nv untouched", 32'h0ABC, rdat);
        cmd(32'h0);
        @(posedge aclk);
        trip_req <= 1'h1;
        @(posedge aclk);
        trip_req <= 1'h0;
        poll(SBIT_FAULT, 1'h1, "fault set");
        cmd(32'h0400_0000);
        poll(SBIT_FAULT, 1'h0, "fault cleared");
        cmd(32'h0);
        rd(8'h30);
        chk("unmapped resp", RESP_SLVERR, rrsp);
        chk("unmapped data", 32'h0, rdat);
        tally_and_finish();
    end
endmodule // drive_link_command_handshake_test
